/* pkg/tovc_map.svh */
/*
 Register offsets, field positions and reset values for the
 timer overflow control block. Assumes a plain byte-wide register port.
*/
`ifndef TOVC_MAP_SVH
`define TOVC_MAP_SVH
// ---------------------------------------------------------------
// offsets
// ---------------------------------------------------------------
`define TOVC_SC_ADDR 4'h0
`define TOVC_MOD_LO_ADDR 4'h1
`define TOVC_MOD_HI_ADDR 4'h2
`define TOVC_CNT_LO_ADDR 4'h3
`define TOVC_CNT_HI_ADDR 4'h4
`define TOVC_IRQ_STAT_ADDR 4'h5
`define TOVC_IRQ_MASK_ADDR 4'h6
// ---------------------------------------------------------------
// fields
// ---------------------------------------------------------------
`define TOVC_FLAG_BIT 7
`define TOVC_IEN_BIT 6
`define TOVC_CAS_BIT 5
`define TOVC_CLKS_HI 4
`define TOVC_CLKS_LO 3
`define TOVC_PS_HI 2
`define TOVC_PS_LO 0
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define TOVC_SC_RESET 8'h00
`define TOVC_MOD_RESET 16'hFFFF
`define TOVC_CNT_ZERO 16'h0000
`define TOVC_IRQ_RESET 8'h00
`endif

/* pkg/tovc_pkg.sv */
/*
 Types for the timer overflow control block.
 Assumes tovc_map.svh for the numeric constants.
*/
package tovc_pkg;
    typedef enum logic [1:0] {
        TOVC_SRC_OFF,
        TOVC_SRC_BUS,
        TOVC_SRC_FIXED,
        TOVC_SRC_EXT
    } tovc_src_t;
    typedef enum logic {
        TOVC_DIR_UP,
        TOVC_DIR_DOWN
    } tovc_dir_t;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tovc_bus_t;
endpackage

/* src/tovc_timer.sv */
/*
 Timer overflow control: status/control register, counter with modulo,
 clock source selection, prescaler, wrap flag and interrupt.
 Assumes one bus clock; fixed-rate and external clocks are async pins.
*/
// Decided for this implementation: the strobed register port and the register offsets.
`include "tovc_map.svh"
`timescale 1ns/100ps
`default_nettype none
module tovc_timer
(
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // register port
    input wire tovc_pkg::tovc_bus_t bus,
    output logic [7:0] rdata,
    // async clock pins
    input wire logic fixed_rate_clock,
    input wire logic ext_clock,
    // status
    output logic [15:0] count,
    output logic count_down,
    output logic center_aligned_pwm,
    output logic irq
);
    import tovc_pkg::*;

    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    logic rst_s1_reg;
    logic rst_s2_reg;
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    wire rst_n = rst_s2_reg;

    // ---------------------------------------------------------------
    // clock pin synchronizers and edge detect
    // ---------------------------------------------------------------
    logic [2:0] fix_sync_reg;
    logic [2:0] ext_sync_reg;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fix_sync_reg <= 3'h0;
            ext_sync_reg <= 3'h0;
        end
        else
        begin
            fix_sync_reg <= {fix_sync_reg[1:0], fixed_rate_clock};
            ext_sync_reg <= {ext_sync_reg[1:0], ext_clock};
        end
    end
    // only stages 1 and 2 are read; stage 0 feeds stage 1 alone
    wire fix_rise = fix_sync_reg[1] & ~fix_sync_reg[2];
    wire ext_rise = ext_sync_reg[1] & ~ext_sync_reg[2];

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic flag_reg;
    logic ien_reg;
    logic cas_reg;
    logic [1:0] clks_reg;
    logic [2:0] ps_reg;
    logic [15:0] mod_reg;
    logic [15:0] cnt_reg;
    logic [6:0] pre_reg;
    logic dir_reg;
    logic armed_reg;
    logic wrap_stat_reg;
    logic wrap_mask_reg;
    logic irq_reg;
    logic [7:0] rdata_reg;

    // ---------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------
    wire wr_sc = bus.wr && (bus.addr == `TOVC_SC_ADDR);
    wire rd_sc = bus.rd && (bus.addr == `TOVC_SC_ADDR);
    wire wr_mlo = bus.wr && (bus.addr == `TOVC_MOD_LO_ADDR);
    wire wr_mhi = bus.wr && (bus.addr == `TOVC_MOD_HI_ADDR);
    wire wr_cnt = bus.wr && ((bus.addr == `TOVC_CNT_LO_ADDR) ||
                             (bus.addr == `TOVC_CNT_HI_ADDR));
    wire rd_stat = bus.rd && (bus.addr == `TOVC_IRQ_STAT_ADDR);
    wire wr_mask = bus.wr && (bus.addr == `TOVC_IRQ_MASK_ADDR);

    // ---------------------------------------------------------------
    // source select and prescaler
    // ---------------------------------------------------------------
    tovc_src_t src;
    assign src = tovc_src_t'(clks_reg);
    wire src_tick = (src == TOVC_SRC_BUS) ? 1'b1 :
                    (src == TOVC_SRC_FIXED) ? fix_rise :
                    (src == TOVC_SRC_EXT) ? ext_rise : 1'b0;
    // divide by 2**p: tick when the low p bits of the prescale count wrap
    wire [6:0] pre_mask = 7'(({7'h00, 1'b1} << ps_reg) - 8'h01);
    wire pre_done = ((pre_reg & pre_mask) == pre_mask);
    wire cnt_tick = src_tick && pre_done;
    wire [6:0] pre_next = src_tick ? (pre_done ? 7'h00 : pre_reg + 7'h01)
                                   : pre_reg;

    // ---------------------------------------------------------------
    // counter and wrap event
    // ---------------------------------------------------------------
    wire at_mod = (cnt_reg >= mod_reg);
    wire at_zero = (cnt_reg == `TOVC_CNT_ZERO);
    logic [15:0] cnt_next;
    logic dir_next;
    logic wrap;
    always_comb
    begin
        cnt_next = cnt_reg;
        dir_next = dir_reg;
        wrap = 1'b0;
        if (!cas_reg)
            dir_next = TOVC_DIR_UP;
        if (cnt_tick)
        begin
            if (!cas_reg)
            begin
                dir_next = TOVC_DIR_UP;
                if (at_mod)
                begin
                    cnt_next = `TOVC_CNT_ZERO;
                    wrap = 1'b1;
                end
                else
                    cnt_next = cnt_reg + 16'h0001;
            end
            else if (dir_reg == TOVC_DIR_UP)
            begin
                if (at_mod)
                begin
                    dir_next = TOVC_DIR_DOWN;
                    cnt_next = cnt_reg - 16'h0001;
                    wrap = 1'b1;
                end
                else
                    cnt_next = cnt_reg + 16'h0001;
            end
            else
            begin
                if (at_zero)
                begin
                    dir_next = TOVC_DIR_UP;
                    cnt_next = cnt_reg + 16'h0001;
                end
                else
                    cnt_next = cnt_reg - 16'h0001;
            end
        end
        if (wr_cnt)
        begin
            cnt_next = `TOVC_CNT_ZERO;
            dir_next = TOVC_DIR_UP;
        end
    end

    // ---------------------------------------------------------------
    // wrap flag clear sequence
    // ---------------------------------------------------------------
    // a wrap disarms, so the pending write of 0 cannot clear it
    wire clear_ok = wr_sc && armed_reg &&
                    !bus.wdata[`TOVC_FLAG_BIT];
    wire flag_next = wrap ? 1'b1 : (clear_ok ? 1'b0 : flag_reg);
    wire armed_next = wrap ? 1'b0 :
                      (rd_sc && flag_reg) ? 1'b1 :
                      wr_sc ? 1'b0 : armed_reg;
    wire stat_next = wrap ? 1'b1 : (rd_stat ? 1'b0 : wrap_stat_reg);

    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    wire [7:0] sc_view = {flag_reg, ien_reg, cas_reg, clks_reg, ps_reg};
    wire [7:0] rd_mux =
        (bus.addr == `TOVC_SC_ADDR) ? sc_view :
        (bus.addr == `TOVC_MOD_LO_ADDR) ? mod_reg[7:0] :
        (bus.addr == `TOVC_MOD_HI_ADDR) ? mod_reg[15:8] :
        (bus.addr == `TOVC_CNT_LO_ADDR) ? cnt_reg[7:0] :
        (bus.addr == `TOVC_CNT_HI_ADDR) ? cnt_reg[15:8] :
        (bus.addr == `TOVC_IRQ_STAT_ADDR) ? {7'h00, wrap_stat_reg} :
        (bus.addr == `TOVC_IRQ_MASK_ADDR) ? {7'h00, wrap_mask_reg} : 8'h00;
    wire irq_next = (ien_reg && flag_next) ||
                    (wrap_mask_reg && stat_next);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flag_reg <= 1'b0;
            armed_reg <= 1'b0;
            {ien_reg, cas_reg, clks_reg, ps_reg} <= 7'(`TOVC_SC_RESET);
            mod_reg <= `TOVC_MOD_RESET;
            cnt_reg <= `TOVC_CNT_ZERO;
            pre_reg <= 7'h00;
            dir_reg <= TOVC_DIR_UP;
            wrap_stat_reg <= 1'b0;
            wrap_mask_reg <= 1'b0;
            irq_reg <= 1'b0;
            rdata_reg <= `TOVC_IRQ_RESET;
        end
        else
        begin
            flag_reg <= flag_next;
            armed_reg <= armed_next;
            if (wr_sc)
            begin
                ien_reg <= bus.wdata[`TOVC_IEN_BIT];
                cas_reg <= bus.wdata[`TOVC_CAS_BIT];
                clks_reg <= bus.wdata[`TOVC_CLKS_HI:`TOVC_CLKS_LO];
                ps_reg <= bus.wdata[`TOVC_PS_HI:`TOVC_PS_LO];
            end
            if (wr_mlo)
                mod_reg[7:0] <= bus.wdata;
            if (wr_mhi)
                mod_reg[15:8] <= bus.wdata;
            if (wr_mask)
                wrap_mask_reg <= bus.wdata[0];
            cnt_reg <= cnt_next;
            dir_reg <= dir_next;
            pre_reg <= wr_cnt ? 7'h00 : pre_next;
            wrap_stat_reg <= stat_next;
            irq_reg <= irq_next;
            rdata_reg <= bus.rd ? rd_mux : 8'h00;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign rdata = rdata_reg;
    assign count = cnt_reg;
    assign count_down = dir_reg;
    assign center_aligned_pwm = cas_reg;
    assign irq = irq_reg;
endmodule
`default_nettype wire

/* verif/tovc_timer_asserts.sv */
/*
 Port checker for tovc_timer.
 Assumes it is bound to tovc_timer and sees one bus clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tovc_timer_asserts
import tovc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // register port
    input wire tovc_pkg::tovc_bus_t bus,
    input wire logic [7:0] rdata,
    // pins and status
    input wire logic fixed_rate_clock,
    input wire logic ext_clock,
    input wire logic [15:0] count,
    input wire logic count_down,
    input wire logic center_aligned_pwm,
    input wire logic irq
);
    // ------------------------------------------------------------
    // shadow of software writes
    // ------------------------------------------------------------
    logic [7:0] sc_reg;
    logic msk_reg;
    logic arm_reg;
    wire logic sc_wr = bus.wr && bus.addr == 4'h0;
    wire logic sc_rd = bus.rd && bus.addr == 4'h0;
    wire logic msk_wr = bus.wr && bus.addr == 4'h6;
    // arm only approximates: any control read arms it, even with the flag clear
    always_ff @(posedge clock or negedge rstn)
        if (!rstn)
        begin
            sc_reg <= 8'h00;
            msk_reg <= 1'b0;
            arm_reg <= 1'b0;
        end
        else
        begin
            sc_reg <= sc_wr ? bus.wdata : sc_reg;
            msk_reg <= msk_wr ? bus.wdata[0] : msk_reg;
            arm_reg <= sc_rd | (arm_reg & ~sc_wr);
        end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    sequence up_to_zero;
        count == 16'h0000 && $past(count) != 16'h0000 && !$past(count_down);
    endsequence
    sc_readback_a: assert property (sc_rd |=>
        rdata[6:0] == $past(sc_reg[6:0])) else $error("control readback");
    off_hold_a: assert property (sc_reg[4:3] == 2'h0 &&
        $past(sc_reg[4:3]) == 2'h0 && !$past(bus.wr) |-> $stable(count))
        else $error("counter moved while off");
    bus_step_a: assert property (sc_reg[4:0] == 5'h08 &&
        $past(sc_reg[4:0]) == 5'h08 && !$past(bus.wr) && !count_down &&
        !$past(count_down) |-> count == $past(count) + 16'h0001 ||
        count == 16'h0000) else $error("bus clock step wrong");
    up_only_a: assert property (!center_aligned_pwm [*3] |-> !count_down)
        else $error("down count without center mode");
    pwm_copy_a: assert property ($stable(sc_reg[5]) [*2] |->
        center_aligned_pwm == sc_reg[5]) else $error("center output wrong");
    up_wrap_a: assert property (up_to_zero ##0 !$past(bus.wr) &&
        sc_reg[6] |-> ##[0:1] irq) else $error("no irq on wrap");
    down_wrap_a: assert property ($rose(count_down) &&
        !$past(bus.wr) && sc_reg[6] |-> ##[0:1] irq)
        else $error("no irq on center wrap");
    set_only_a: assert property (irq && !msk_reg && sc_wr &&
        bus.wdata[7:6] == 2'h3 |=> irq [*2]) else $error("one cleared flag");
    no_arm_a: assert property (irq && !msk_reg && sc_wr &&
        bus.wdata[6] && !arm_reg |=> irq [*2]) else $error("clear unarmed");
    irq_cause_a: assert property (irq |-> sc_reg[6] ||
        $past(sc_reg[6]) || msk_reg || $past(msk_reg))
        else $error("irq without enable");
endmodule
bind tovc_timer tovc_timer_asserts i_chk (.clock(clock), .rstn(rstn),
    .bus(bus), .rdata(rdata), .fixed_rate_clock(fixed_rate_clock),
    .ext_clock(ext_clock), .count(count), .count_down(count_down),
    .center_aligned_pwm(center_aligned_pwm), .irq(irq));
`default_nettype wire

/* verif/tovc_timer_tb.sv */
/*
 Self-checking bench for tovc_timer.
 Assumes the design and its bound checker are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tovc_timer_tb;
    import tovc_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    tovc_bus_t bus = '0;
    logic fixed_rate_clock = 1'b0;
    logic ext_clock = 1'b0;
    logic [7:0] rdata;
    logic [15:0] count;
    logic count_down, center_aligned_pwm, irq;
    logic rd_pend = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] w;
    int failures = 0;
    int comparisons = 0;
    always #2 clock = ~clock;
    tovc_timer i_dut (.clock(clock), .rstn(rstn), .bus(bus), .rdata(rdata),
        .fixed_rate_clock(fixed_rate_clock), .ext_clock(ext_clock),
        .count(count), .count_down(count_down),
        .center_aligned_pwm(center_aligned_pwm), .irq(irq));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // one gap cycle after each strobe keeps drivers single per step
    task automatic acc(input logic [3:0] a, input logic [7:0] d, logic r);
        bus <= '{addr: a, wdata: d, wr: !r, rd: r};
        if (r)
            exp_q.push_back(d);
        @(posedge clock);
        bus.wr <= 1'b0;
        bus.rd <= 1'b0;
        @(posedge clock);
    endtask
    task automatic await(input logic down, input logic [15:0] v);
        int i;
        for (i = 0; i < 400; i++)
        begin
            @(negedge clock);
            if (down ? count_down === 1'b1 : count === v)
                break;
        end
        if (i == 400)
        begin
            failures++;
            end_of_test();
        end
        @(posedge clock);
    endtask
    task automatic wrap();
        await(1'b0, 16'h0005);
        await(1'b0, 16'h0000);
    endtask
    task automatic look(input logic want);
        repeat (2) @(negedge clock);
        chk(16'(irq), 16'(want));
        @(posedge clock);
    endtask
    task automatic pulse(input logic sel, input int n);
        repeat (n)
        begin
            {ext_clock, fixed_rate_clock} <= sel ? 2'b10 : 2'b01;
            repeat (4) @(posedge clock);
            {ext_clock, fixed_rate_clock} <= 2'b00;
            repeat (4) @(posedge clock);
        end
    endtask
    always @(posedge clock)
        rd_pend <= bus.rd;
    always @(negedge clock)
        if (rd_pend)
            chk(16'(rdata), 16'(exp_q.pop_front()));
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(83146));
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        acc(4'h0, 8'h00, 1);
        acc(4'h1, 8'hFF, 1);
        acc(4'hF, 8'h00, 1);
        $display("reset values done");
        for (int k = 0; k < 8; k++)
        begin
            w = 8'($urandom);
            w[4:3] = k[1:0];
            acc(4'h0, w, 0);
            acc(4'h0, {1'b0, w[6:0]}, 1);
        end
        $display("control fields done");
        acc(4'h1, 8'h05, 0);
        acc(4'h2, 8'h00, 0);
        acc(4'h3, 8'h00, 0);
        acc(4'h0, 8'h48, 0);
        wrap();
        look(1'b1);
        acc(4'h0, 8'hC8, 1);
        wrap();
        acc(4'h0, 8'h48, 0);
        acc(4'h0, 8'hC8, 1);
        acc(4'h0, 8'hC0, 0);
        acc(4'h0, 8'h40, 0);
        acc(4'h0, 8'hC0, 1);
        acc(4'h0, 8'h40, 0);
        acc(4'h0, 8'h40, 1);
        look(1'b0);
        $display("wrap flag done");
        acc(4'h5, 8'h01, 1);
        acc(4'h5, 8'h00, 1);
        acc(4'h6, 8'h01, 0);
        acc(4'h3, 8'h00, 0);
        acc(4'h0, 8'h08, 0);
        wrap();
        acc(4'h0, 8'h00, 0);
        look(1'b1);
        acc(4'h0, 8'h80, 1);
        acc(4'h0, 8'h00, 0);
        acc(4'h5, 8'h01, 1);
        look(1'b0);
        acc(4'h6, 8'h00, 0);
        $display("interrupt done");
        acc(4'h3, 8'h00, 0);
        acc(4'h0, 8'h68, 0);
        await(1'b1, 16'h0000);
        look(1'b1);
        chk(16'(center_aligned_pwm), 16'h0001);
        acc(4'h0, 8'h60, 0);
        acc(4'h0, 8'h40, 0);
        @(negedge clock);
        chk(16'(count_down), 16'h0000);
        @(posedge clock);
        $display("center mode done");
        for (int k = 0; k < 2; k++)
        begin
            acc(4'h3, 8'h00, 0);
            acc(4'h0, k[0] ? 8'h1A : 8'h11, 0);
            pulse(k[0], 8);
            repeat (6) @(negedge clock);
            chk(count, k[0] ? 16'h0002 : 16'h0004);
            @(posedge clock);
        end
        $display("prescale done");
        end_of_test();
    end
endmodule
`default_nettype wire
